// file: rtl/irv_reset_vector.sv
// reset merge, boot sequence, watchdog and interrupt priority unit
//
// Function
// - three reset sources (pin, key entry, watchdog) reset the internal circuits.
// - low reset pin holds reset; outside holds it long enough after power-up.
// - all selected key inputs low together trigger a reset.
// - key-entry reset is off after reset until software turns it on.
// - watchdog overflows unless restarted within each four-second period.
// - select bit 1 routes overflow to reset, 0 routes it to nmi.
// - watchdog reset is off after reset until software enables it.
// - on release the core fetches the reset vector at table start.
// - after release wait 64 cycles, then hold 32 cycles, then boot.
// - released core runs synchronous to the internal oscillator clock.
// - reset clears core general registers, stack pointer and status word.
// - reset leaves internal ram contents alone.
// - reset returns peripheral registers to their defaults.
// - vector address is base plus four times vector number; 0..3 fixed.
// - only vectors 4,7,8,10,11,14,16,18 belong to maskable systems.
// - equal levels: lower vector number wins.
// - eight maskable systems, each with its own level of eight.
// - per-cause enables live in the peripherals, not here.
// - unit drives request, level and vector number to the core.
// - four clock timer causes merge into one request.
// - vector base is 0x8000 after reset.
// - level zero requests are never accepted; all levels reset to zero.
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps

module irv_reset_vector
  import irv_pkg::*;
#(
  parameter int unsigned WDOG_CYC_P = int'(WDOG_CYC)
)
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ext_reset_n_i,
  input wire logic [3:0] key_reset_inputs_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic irq_port_i,
  input wire logic [3:0] irq_ctimer_i,
  input wire logic irq_rtc_i,
  input wire logic irq_lcd_i,
  input wire logic irq_pwm_i,
  input wire logic irq_tmr8_i,
  input wire logic irq_uart_i,
  input wire logic irq_spi_i,
  output logic sys_reset_n_o,
  output logic boot_fetch_o,
  output logic [23:0] boot_vector_addr_o,
  output logic [23:0] vector_base_addr_o,
  output logic nmi_o,
  output logic [23:0] nmi_vector_addr_o,
  output logic irq_req_o,
  output logic [2:0] irq_level_o,
  output logic [4:0] irq_vector_o,
  output logic [23:0] irq_vector_addr_o
);

  irv_state_s cur_ff;
  irv_state_s nxt_st;

  logic [23:0] vbase;
  logic [NUM_SYS-1:0] sys_req;
  logic key_hit;
  logic wdog_ovf;
  logic wdog_rst;
  logic src_any;
  logic bus_req;
  logic bus_done;
  logic wr_ok;
  logic [8:0] arb;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  // table entry address of a vector
  function automatic logic [23:0] vec_addr(input logic [23:0] base, input logic [4:0] num);
    vec_addr = base + {17'h00000, num, 2'h0};
  endfunction : vec_addr

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    be_merge = res;
  endfunction : be_merge

  // pick highest level; ties keep the earlier, lower-numbered vector
  function automatic logic [8:0] arbitrate(input logic [23:0] lv, input logic [7:0] rq);
    logic [2:0] best;
    logic [4:0] vec;
    logic hit;
    best = 3'h0;
    vec = 5'h00;
    hit = 1'b0;
    for (int i = 0; i < NUM_SYS; i++)
    begin
      if (rq[i] && (lv[i*3 +: 3] > best))
      begin
        best = lv[i*3 +: 3];
        vec = SYS_VEC[i];
        hit = 1'b1;
      end
    end
    arbitrate = {hit, best, vec};
  endfunction : arbitrate

  assign vbase = {cur_ff.vbase_hi, 8'h00};

  // requests arrive already gated by each peripheral's own cause enables
  assign sys_req = {irq_spi_i, irq_uart_i, irq_tmr8_i, irq_pwm_i, irq_lcd_i, irq_rtc_i,
                    |irq_ctimer_i, irq_port_i};

  // empty selection never fires, else an idle mask would reset forever
  assign key_hit = cur_ff.key_en && (cur_ff.key_sel != 4'h0) &&
                   ((cur_ff.key_s2 & cur_ff.key_sel) == 4'h0);

  assign wdog_ovf = cur_ff.wdog_en &&
                    (cur_ff.wdog_cnt == WDOG_W'(WDOG_CYC_P - 1));
  assign wdog_rst = wdog_ovf && cur_ff.wdog_rst_sel;
  assign src_any = !cur_ff.ext_sync[1] || key_hit || wdog_rst;

  assign bus_req = avs_read_i || avs_write_i;
  assign bus_done = bus_req && cur_ff.ack;
  // writes land only while running; during reset every writable register holds defaults
  assign wr_ok = bus_done && avs_write_i && (cur_ff.state == ST_RUN) && !src_any;
  assign arb = arbitrate(cur_ff.levels, sys_req);

  assign ctrl_rd = {22'h000000, cur_ff.wdog_rst_sel, cur_ff.wdog_en,
                    cur_ff.key_sel, 3'h0, cur_ff.key_en};
  assign stat_rd = {13'h0000, cur_ff.cause, 3'h0, cur_ff.irq_vec,
                    1'b0, cur_ff.irq_lvl, 3'h0, cur_ff.irq_req};

  always_comb
  begin
    nxt_st = cur_ff;

    // pin synchronisers
    nxt_st.ext_sync = {cur_ff.ext_sync[0], ext_reset_n_i};
    nxt_st.key_s1 = key_reset_inputs_i;
    nxt_st.key_s2 = cur_ff.key_s1;

    // watchdog count, restarted by software or on overflow
    if (!cur_ff.wdog_en || wdog_ovf)
    begin
      nxt_st.wdog_cnt = '0;
    end
    else
    begin
      nxt_st.wdog_cnt = cur_ff.wdog_cnt + WDOG_W'(1);
    end
    nxt_st.nmi = wdog_ovf && !cur_ff.wdog_rst_sel && (cur_ff.state == ST_RUN);

    // boot sequence
    nxt_st.boot = 1'b0;
    unique case (cur_ff.state)
      ST_RESET:
      begin
        nxt_st.seq_cnt = '0;
        if (!src_any)
        begin
          nxt_st.state = ST_STAB;
        end
      end
      ST_STAB:
      begin
        nxt_st.seq_cnt = cur_ff.seq_cnt + SEQ_W'(1);
        if (cur_ff.seq_cnt == SEQ_W'(STAB_CYC - 1))
        begin
          nxt_st.seq_cnt = '0;
          nxt_st.state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        nxt_st.seq_cnt = cur_ff.seq_cnt + SEQ_W'(1);
        if (cur_ff.seq_cnt == SEQ_W'(HOLD_CYC - 1))
        begin
          nxt_st.seq_cnt = '0;
          nxt_st.state = ST_RUN;
          nxt_st.boot = 1'b1;
          nxt_st.boot_addr = vec_addr(vbase, VEC_RESET);
        end
      end
      ST_RUN:
      begin
        nxt_st.seq_cnt = '0;
      end
    endcase

    // interrupt request to the core, one cycle behind the inputs
    nxt_st.irq_req = arb[8] && (cur_ff.state == ST_RUN);
    nxt_st.irq_lvl = arb[7:5];
    nxt_st.irq_vec = arb[4:0];
    nxt_st.irq_addr = vec_addr(vbase, arb[4:0]);

    // bus slave: one wait cycle, read data captured before waitrequest drops
    nxt_st.ack = bus_req && !cur_ff.ack;
    if (bus_req && !cur_ff.ack)
    begin
      // decode is exact; unmapped offsets and the restart strobe read as zero
      unique case (avs_address_i)
        OFS_CTRL:
        begin
          nxt_st.rdata = ctrl_rd;
        end
        OFS_LEVELS:
        begin
          nxt_st.rdata = {8'h00, cur_ff.levels};
        end
        OFS_VBASE:
        begin
          nxt_st.rdata = {8'h00, vbase};
        end
        OFS_STATUS:
        begin
          nxt_st.rdata = stat_rd;
        end
        default:
        begin
          nxt_st.rdata = 32'h00000000;
        end
      endcase
    end

    if (wr_ok)
    begin
      unique case (avs_address_i)
        OFS_CTRL:
        begin
          logic [31:0] c;
          c = be_merge(ctrl_rd, avs_writedata_i, avs_byteenable_i);
          nxt_st.key_en = c[CTRL_KEY_EN];
          nxt_st.key_sel = c[CTRL_KEY_SEL_LO +: 4];
          nxt_st.wdog_en = c[CTRL_WDOG_EN];
          nxt_st.wdog_rst_sel = c[CTRL_WDOG_RST_SEL];
        end
        OFS_WDOG_RESTART:
        begin
          nxt_st.wdog_cnt = '0;
        end
        OFS_LEVELS:
        begin
          logic [31:0] l;
          l = be_merge({8'h00, cur_ff.levels}, avs_writedata_i, avs_byteenable_i);
          nxt_st.levels = l[23:0];
        end
        OFS_VBASE:
        begin
          logic [31:0] v;
          v = be_merge({8'h00, vbase}, avs_writedata_i, avs_byteenable_i);
          nxt_st.vbase_hi = v[23:8]; // low byte stays zero
        end
        default:
        begin
          // status and unmapped offsets: the write is taken and dropped
          nxt_st.ack = 1'b0;
        end
      endcase
    end

    // any source: back to reset, defaults restored, cause recorded
    if (src_any)
    begin
      nxt_st.state = ST_RESET;
      nxt_st.seq_cnt = '0;
      // while held, later sources add to the record; a fresh entry starts anew
      if (cur_ff.state == ST_RESET)
      begin
        nxt_st.cause = cur_ff.cause | {wdog_rst, key_hit, !cur_ff.ext_sync[1]};
      end
      else
      begin
        nxt_st.cause = {wdog_rst, key_hit, !cur_ff.ext_sync[1]};
      end
    end
    if (src_any || (cur_ff.state != ST_RUN))
    begin
      nxt_st.key_en = 1'b0;
      nxt_st.key_sel = KEY_SEL_RST;
      nxt_st.wdog_en = 1'b0;
      nxt_st.wdog_rst_sel = 1'b0;
      nxt_st.wdog_cnt = '0;
      nxt_st.levels = LEVELS_RST;
      nxt_st.vbase_hi = VBASE_RST[23:8];
      nxt_st.nmi = 1'b0;
      nxt_st.irq_req = 1'b0;
    end
  end

  // ram is not in this reset tree, its contents survive every source
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cur_ff <= '{
        ext_sync: 2'h0,
        key_s1: 4'hF,
        key_s2: 4'hF,
        state: ST_RESET,
        seq_cnt: '0,
        wdog_cnt: '0,
        key_en: 1'b0,
        key_sel: KEY_SEL_RST,
        wdog_en: 1'b0,
        wdog_rst_sel: 1'b0,
        levels: LEVELS_RST,
        vbase_hi: VBASE_RST[23:8],
        cause: 3'h1,
        ack: 1'b0,
        rdata: 32'h00000000,
        nmi: 1'b0,
        boot: 1'b0,
        boot_addr: VBASE_RST,
        irq_req: 1'b0,
        irq_lvl: 3'h0,
        irq_vec: 5'h00,
        irq_addr: VBASE_RST
      };
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  // release is a registered state, so the core leaves reset on a clock edge
  assign sys_reset_n_o = (cur_ff.state == ST_RUN);
  assign boot_fetch_o = cur_ff.boot;
  assign boot_vector_addr_o = cur_ff.boot_addr;
  assign vector_base_addr_o = vbase;
  assign nmi_o = cur_ff.nmi;
  assign nmi_vector_addr_o = vec_addr(vbase, VEC_NMI);
  assign irq_req_o = cur_ff.irq_req;
  assign irq_level_o = cur_ff.irq_lvl;
  assign irq_vector_o = cur_ff.irq_vec;
  assign irq_vector_addr_o = cur_ff.irq_addr;
  assign avs_readdata_o = cur_ff.rdata;
  assign avs_waitrequest_o = bus_req && !cur_ff.ack;

endmodule : irv_reset_vector

// file: include/irv_pkg.sv
// package: constants, register map and types of the reset and vectoring block
package irv_pkg;

  // clock and timing
  localparam longint unsigned CLK_HZ = 64'd50_000_000;
  localparam int unsigned STAB_CYC = 64;
  localparam int unsigned HOLD_CYC = 32;
  localparam longint unsigned WDOG_PERIOD_S = 64'd4;
  localparam longint unsigned WDOG_CYC = WDOG_PERIOD_S * CLK_HZ;
  localparam int unsigned WDOG_W = 28;
  localparam int unsigned SEQ_W = 7;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WDOG_RESTART = 8'h04;
  localparam logic [7:0] OFS_LEVELS = 8'h08;
  localparam logic [7:0] OFS_VBASE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control register fields
  localparam int unsigned CTRL_KEY_EN = 0;
  localparam int unsigned CTRL_KEY_SEL_LO = 4;
  localparam int unsigned CTRL_WDOG_EN = 8;
  localparam int unsigned CTRL_WDOG_RST_SEL = 9;

  // status register fields
  localparam int unsigned STAT_IRQ_REQ = 0;
  localparam int unsigned STAT_IRQ_LVL_LO = 4;
  localparam int unsigned STAT_IRQ_VEC_LO = 8;
  localparam int unsigned STAT_CAUSE_LO = 16;

  // values after reset
  localparam logic [3:0] KEY_SEL_RST = 4'h0;
  localparam logic [23:0] LEVELS_RST = 24'h000000;
  localparam logic [23:0] VBASE_RST = 24'h008000;

  // vector numbers
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_MISALIGN = 5'h01;
  localparam logic [4:0] VEC_NMI = 5'h02;
  localparam logic [4:0] VEC_RSVD = 5'h03;
  localparam int unsigned NUM_SYS = 8;
  // system index 0..7 in ascending vector order: port, clock timer, rtc, lcd,
  // pwm, 8-bit timer, uart, spi
  localparam logic [NUM_SYS-1:0][4:0] SYS_VEC =
    {5'h12, 5'h10, 5'h0E, 5'h0B, 5'h0A, 5'h08, 5'h07, 5'h04};

  typedef enum logic [1:0] {
    ST_RESET,
    ST_STAB,
    ST_HOLD,
    ST_RUN
  } irv_state_e;

  typedef struct packed {
    logic [1:0] ext_sync;
    logic [3:0] key_s1;
    logic [3:0] key_s2;
    irv_state_e state;
    logic [SEQ_W-1:0] seq_cnt;
    logic [WDOG_W-1:0] wdog_cnt;
    logic key_en;
    logic [3:0] key_sel;
    logic wdog_en;
    logic wdog_rst_sel;
    logic [23:0] levels;
    logic [15:0] vbase_hi;
    logic [2:0] cause;
    logic ack;
    logic [31:0] rdata;
    logic nmi;
    logic boot;
    logic [23:0] boot_addr;
    logic irq_req;
    logic [2:0] irq_lvl;
    logic [4:0] irq_vec;
    logic [23:0] irq_addr;
  } irv_state_s;

endpackage : irv_pkg

// file: tb/irv_reset_vector_properties.sv
// checker: reset release timing and vector outputs
`timescale 1ns/100ps
module irv_reset_vector_checker
  import irv_pkg::*;
#(
  parameter int unsigned WDOG_CYC_P = 50
)
(
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ext_reset_n_i,
  input wire logic sys_reset_n_o,
  input wire logic boot_fetch_o,
  input wire logic [23:0] boot_vector_addr_o,
  input wire logic [23:0] vector_base_addr_o,
  input wire logic nmi_o,
  input wire logic [23:0] nmi_vector_addr_o,
  input wire logic irq_req_o,
  input wire logic [2:0] irq_level_o,
  input wire logic [4:0] irq_vector_o,
  input wire logic [23:0] irq_vector_addr_o
);
  // cycles spent in reset with the pin high; saturates so it never wraps
  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;
  assign nxt_low_cnt = (sys_reset_n_o || !ext_reset_n_i) ? 8'h00 :
    (low_cnt_ff == 8'hFF) ? low_cnt_ff : low_cnt_ff + 8'h01;
  always_ff @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      low_cnt_ff <= 8'h00;
    else
      low_cnt_ff <= nxt_low_cnt;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  boot_pulse_a: assert property (boot_fetch_o |-> $rose(sys_reset_n_o) ##1 !boot_fetch_o)
    else $error("boot pulse not on release");
  boot_addr_a: assert property (boot_fetch_o |-> boot_vector_addr_o == vector_base_addr_o)
    else $error("boot address not base");
  hold_time_a: assert property ($rose(sys_reset_n_o) |-> low_cnt_ff >= 8'd96)
    else $error("reset released early");
  pin_reset_a: assert property ($fell(ext_reset_n_i) |-> ##[1:4] !sys_reset_n_o)
    else $error("pin low did not reset");
  nmi_addr_a: assert property (nmi_vector_addr_o == vector_base_addr_o + 24'h000008)
    else $error("nmi vector address wrong");
  irq_addr_a: assert property (irq_req_o |->
    irq_vector_addr_o == $past(vector_base_addr_o) + {17'h00000, irq_vector_o, 2'b00})
    else $error("irq vector address wrong");
  irq_vec_a: assert property (irq_req_o |-> irq_vector_o inside {4, 7, 8, 10, 11, 14, 16, 18})
    else $error("irq vector not assigned");
  irq_level_a: assert property (irq_req_o |-> irq_level_o != 3'h0)
    else $error("level zero request");
  irq_quiet_a: assert property (!sys_reset_n_o |=> !irq_req_o)
    else $error("request during reset");
  nmi_pulse_a: assert property (nmi_o |-> sys_reset_n_o ##1 !nmi_o)
    else $error("nmi not a single pulse");
endmodule : irv_reset_vector_checker

bind irv_reset_vector irv_reset_vector_checker #(.WDOG_CYC_P(WDOG_CYC_P)) u_chk (
  .core_clk_i, .arst_n_i, .ext_reset_n_i, .sys_reset_n_o, .boot_fetch_o,
  .boot_vector_addr_o, .vector_base_addr_o, .nmi_o, .nmi_vector_addr_o,
  .irq_req_o, .irq_level_o, .irq_vector_o, .irq_vector_addr_o);

// file: tb/irv_core_model.sv
// model: cpu core taking the reset vector
`timescale 1ns/100ps
module irv_core_model
(
  input wire logic clk_i,
  input wire logic sys_reset_n_i,
  input wire logic boot_i,
  input wire logic [23:0] boot_addr_i,
  output logic [23:0] pc_o = 24'h000000,
  output logic [7:0] boots_o = 8'h00
);
  logic [15:0] gpr [8];
  logic [15:0] sp;
  logic [7:0] psw;
  // runs on the block clock only
  always @(posedge clk_i)
  begin
    if (!sys_reset_n_i)
    begin
      // core state clears, ram is left alone
      foreach (gpr[i]) gpr[i] <= 16'h0000;
      sp <= 16'h0000;
      psw <= 8'h00;
    end
    else if (boot_i)
    begin
      pc_o <= boot_addr_i;
      boots_o <= boots_o + 8'h01;
    end
  end
endmodule : irv_core_model

// file: tb/test_irv_reset_vector.sv
// testbench: reset sources, boot timing, registers and interrupt priority
`timescale 1ns/100ps
module test_irv_reset_vector
  import irv_pkg::*;
;
  logic core_clk_i, arst_n_i, ext_reset_n_i, avs_read_i, avs_write_i, irq_port_i;
  logic irq_rtc_i, irq_lcd_i, irq_pwm_i, irq_tmr8_i, irq_uart_i, irq_spi_i;
  logic [3:0] key_reset_inputs_i, avs_byteenable_i, irq_ctimer_i;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, r;
  logic avs_waitrequest_o, sys_reset_n_o, boot_fetch_o, nmi_o, irq_req_o;
  logic [23:0] boot_vector_addr_o, vector_base_addr_o, nmi_vector_addr_o;
  logic [23:0] irq_vector_addr_o, core_pc, base;
  logic [2:0] irq_level_o;
  logic [4:0] irq_vector_o;
  logic [7:0] boots, rq;
  int n_errors, tests_run, cyc, nmis, n, best, c0;
  int lv[8];
  int vecs[8] = '{4, 7, 8, 10, 11, 14, 16, 18};

  irv_reset_vector #(.WDOG_CYC_P(50)) i_dut (.core_clk_i, .arst_n_i, .ext_reset_n_i,
    .key_reset_inputs_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_port_i, .irq_ctimer_i,
    .irq_rtc_i, .irq_lcd_i, .irq_pwm_i, .irq_tmr8_i, .irq_uart_i, .irq_spi_i,
    .sys_reset_n_o, .boot_fetch_o, .boot_vector_addr_o, .vector_base_addr_o, .nmi_o,
    .nmi_vector_addr_o, .irq_req_o, .irq_level_o, .irq_vector_o, .irq_vector_addr_o);
  irv_core_model i_core (.clk_i(core_clk_i), .sys_reset_n_i(sys_reset_n_o),
    .boot_i(boot_fetch_o), .boot_addr_i(boot_vector_addr_o), .pc_o(core_pc), .boots_o(boots));

  initial
  begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (nmi_o === 1'b1)
      nmis++;
    if (cyc == 6000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // holds the request until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    n = 0;
    // waitrequest is looked at mid-cycle, where it has settled for the next edge
    @(negedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 20)
      n_errors++;
    @(posedge core_clk_i);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus

  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(q, e);
  endtask : rd

  task wait_lvl(input logic v);
    n = 0;
    while (sys_reset_n_o !== v && n < 400)
    begin
      @(posedge core_clk_i);
      n++;
    end
  endtask : wait_lvl

  task booted(input int k);
    wait_lvl(1'b1);
    repeat (2) @(posedge core_clk_i);
    chk(core_pc, 24'h008000);
    chk(boots, k);
  endtask : booted

  task finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial
  begin
    {arst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} <= '0;
    {irq_port_i, irq_ctimer_i, irq_rtc_i, irq_lcd_i, irq_pwm_i} <= '0;
    {irq_tmr8_i, irq_uart_i, irq_spi_i} <= '0;
    ext_reset_n_i <= 1'b1;
    key_reset_inputs_i <= 4'hF;
    avs_byteenable_i <= 4'hF;
    void'($urandom(38569));
    repeat (10) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    wait_lvl(1'b1);
    chk(n >= 97 && n <= 101, 1);
    booted(1);
    rd(OFS_CTRL, 32'h00000000);
    rd(OFS_LEVELS, 32'h00000000);
    rd(OFS_VBASE, 32'h00008000);
    rd(OFS_STATUS, 32'h00010000);
    rd(8'h20, 32'h00000000);
    key_reset_inputs_i <= 4'h0;
    repeat (8) @(posedge core_clk_i);
    chk(sys_reset_n_o, 1'b1);
    key_reset_inputs_i <= 4'hF;
    bus(1'b1, OFS_VBASE, 32'h00123456);
    base = 24'h123400;
    rd(OFS_VBASE, base);
    chk(nmi_vector_addr_o, base + 24'h000008);
    for (int k = 0; k < 48; k++)
    begin
      if (k % 8 == 0)
      begin
        r = (k == 8) ? 32'hB6DB6D : (k == 16) ? 32'h0 : $urandom & 32'hFFFFFF;
        bus(1'b1, OFS_LEVELS, r);
        for (int i = 0; i < 8; i++)
          lv[i] = (r >> (3 * i)) & 7;
      end
      r = $urandom;
      @(posedge core_clk_i);
      {irq_spi_i, irq_uart_i, irq_tmr8_i, irq_pwm_i, irq_lcd_i, irq_rtc_i} <= r[7:2];
      irq_port_i <= r[0];
      irq_ctimer_i <= r[11:8];
      rq = {r[7:2], |r[11:8], r[0]};
      repeat (2) @(posedge core_clk_i);
      best = -1;
      for (int i = 0; i < 8; i++)
        if (rq[i] && lv[i] != 0 && (best < 0 || lv[i] > lv[best]))
          best = i;
      chk(irq_req_o, best >= 0);
      if (best >= 0)
      begin
        chk(irq_level_o, lv[best]);
        chk(irq_vector_o, vecs[best]);
        chk(irq_vector_addr_o, base + 4 * vecs[best]);
      end
    end
    {irq_port_i, irq_ctimer_i, irq_rtc_i, irq_lcd_i, irq_pwm_i} <= '0;
    {irq_tmr8_i, irq_uart_i, irq_spi_i} <= '0;
    bus(1'b1, OFS_CTRL, 32'h00000100);
    n = 0;
    while (nmi_o !== 1'b1 && n < 200)
    begin
      @(posedge core_clk_i);
      n++;
    end
    chk(n >= 40 && n <= 60, 1);
    // let the pulse counter take the pulse just seen before the baseline
    repeat (2) @(posedge core_clk_i);
    c0 = nmis;
    repeat (30) bus(1'b1, OFS_WDOG_RESTART, 32'h00000000);
    chk(nmis, c0);
    bus(1'b1, OFS_CTRL, 32'h00000300);
    wait_lvl(1'b0);
    chk(sys_reset_n_o, 1'b0);
    booted(2);
    rd(OFS_CTRL, 32'h00000000);
    rd(OFS_VBASE, 32'h00008000);
    bus(1'b1, OFS_CTRL, 32'h00000031);
    key_reset_inputs_i <= 4'hE;
    repeat (8) @(posedge core_clk_i);
    chk(sys_reset_n_o, 1'b1);
    key_reset_inputs_i <= 4'hC;
    wait_lvl(1'b0);
    chk(sys_reset_n_o, 1'b0);
    bus(1'b1, OFS_LEVELS, 32'h00FFFFFF);
    key_reset_inputs_i <= 4'hF;
    booted(3);
    rd(OFS_LEVELS, 32'h00000000);
    rd(OFS_CTRL, 32'h00000000);
    ext_reset_n_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk(sys_reset_n_o, 1'b0);
    ext_reset_n_i <= 1'b1;
    wait_lvl(1'b1);
    chk(n >= 97 && n <= 101, 1);
    finish_test();
  end
endmodule : test_irv_reset_vector
